// ===== rtl/modulator_defs.svh
`ifndef MODULATOR_DEFS_SVH
`define MODULATOR_DEFS_SVH
// What this block does
// - outer deviation from mantissa, exponent, reference and band dividers
// - four-level inner symbols use one third of outer deviation
// - two-level map: code 0 bit1 positive, code 2 inverted
// - four-level map: code 1 swaps magnitudes, codes 2 and 3 negate
// - symbols taken msb pair first; swap reverses bits inside each pair
// - gaussian shaping, bt 1 or 0.5, eight phases per symbol
// - shaping interpolation factor 64, scaled by exponent, off at 11
// - amplitude keying: bit 1 max entry, bit 0 entry zero
// - nonzero mapping code reverses amplitude bit mapping
// - multi-level keying ramps through table, steps of eighth symbols
// - repeated ones hold max power, repeated zeros hold minimum
// - optional linear interpolation of power values, same factor scheme
// - interpolation ticks spaced 8 down to 4 clocks by mantissa
// - smoothing fir inserted when enabled; software sets smoothing bit
// - fir offers filter, ramp and switch configurations
// - polar mode consumes byte pairs per eighth symbol: frequency, power
// - polar frequency byte signed, deviation times byte over 128
// - polar power byte drives amplifier with table coding
// - polar and carrier modes run until the abort command
`define OFF_MODE      6'h00
`define OFF_DEV       6'h04
`define OFF_RATE      6'h08
`define OFF_CMD       6'h0C
`define OFF_STAT      6'h10
`define TABLE_SEL     5
`define TIDX_MSB      4
`define TIDX_LSB      2
`define TABLE_N       8
`define CMD_START     0
`define CMD_ABORT     1
`define MT_2FSK       4'h0
`define MT_4FSK       4'h1
`define MT_2GFSK      4'h2
`define MT_4GFSK      4'h3
`define MT_ASK        4'h5
`define MT_POLAR      4'h6
`define MT_CW         4'h7
`define FIR_FILTER    2'h0
`define FIR_RAMP      2'h1
`define DEV_BASE_ADD  28'h0000100
`define DB_SHIFT      3'h2
`define DEV_ROUND     28'h0000004
`define DEV_DIV_SHIFT 3
`define INNER_DIV     28'h0000003
`define BYTE_MSB      7
`define BYTE_BITS     4'h8
`define PHASE_LAST    3'h7
`define GAUSS_BT1     64'h403E382C20140802
`define GAUSS_BT05    64'h403A332A20160D06
`define GC_W          8
`define GAUSS_SHIFT   6
`define LOG2_MAX      3'h6
`define RATE_E_SCALE  4'h5
`define RATE_E_OFF    4'hB
`define TICK_SLOW     4'h8
`define TICK_FAST     4'h4
`define TICK_M_SHIFT  14
`define POLAR_SHIFT   7
`define OS_N          8
`define OS_FULL       4'h8
`define OS_SHIFT      3
`define PAIR_LEN      2'h2
`endif

// ===== rtl/modulator_pkg.sv
package modulator_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} state_type;

  // mode word, lsb first from mod_type upward
  typedef struct packed {
    logic [1:0] fir_config;
    logic       dig_smooth_enable;
    logic       smoothing_fir_enable;
    logic [1:0] output_filter_cutoff_code;
    logic [2:0] ramp_step_duration;
    logic [2:0] max_power_entry_index;
    logic       power_interp_enable;
    logic       shaping_interp_enable;
    logic       gaussian_bandwidth_select;
    logic       symbol_bit_pair_swap;
    logic [1:0] const_map;
    logic [3:0] mod_type;
  } mode_cfg_type;

  typedef struct packed {
    logic       band_sel_mid;
    logic       ref_div_en;
    logic [3:0] fdev_e;
    logic [7:0] fdev_m;
  } dev_cfg_type;

  typedef struct packed {
    logic [3:0]  rate_e;
    logic [15:0] rate_m;
  } rate_cfg_type;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
endpackage : modulator_pkg

// ===== rtl/digital_fsk_ask_modulator.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "modulator_defs.svh"

module digital_fsk_ask_modulator
  import modulator_pkg::*;
#(
  parameter int FW = 30,  // frequency word width
  parameter int PW = 8    // power code width
) (
  input  wire logic               mclk_in,        // 125 MHz clock
  input  wire logic               srst_in,        // sync reset, high
  input  wire logic               ce_in,          // low freezes all state
  input  wire bus_req_type        bus_in,         // register request
  output logic [31:0]             rdata_out,      // read data, cycle after strobe
  input  wire logic               tick8_in,       // eighth-symbol strobe
  input  wire logic [7:0]         byte_in,        // tx fifo byte
  input  wire logic               byte_valid_in,  // byte offered
  output logic                    byte_ready_out, // byte accepted this cycle
  output logic signed [FW-1:0]    freq_word_out,  // deviation word to synth
  output logic [PW-1:0]           power_level_table_out,   // power code to amplifier
  output logic                    tx_active_out   // transmission running
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  mode_cfg_type       mode_reg, mode_next;
  dev_cfg_type        dev_reg, dev_next;
  rate_cfg_type       rate_reg, rate_next;
  logic [PW-1:0]      power_level_table_reg [`TABLE_N];
  logic [PW-1:0]      table_next [`TABLE_N];
  logic [31:0]        rdata_reg, rdata_next;
  logic [2:0]         tidx;
  logic               start_cmd, abort_command;
  state_type          state_reg, state_next;
  logic               active;
  logic [1:0]         cnt_reg, cnt_next;
  logic [7:0]         buf_reg [2];
  logic [7:0]         buf_next [2];
  logic [7:0]         shift_reg, shift_next, src;
  logic [3:0]         bits_reg, bits_next, bps;
  logic [2:0]         phase_reg, phase_next;
  logic signed [FW-1:0] prev_f_reg, prev_f_next, cur_f_reg, cur_f_next;
  logic signed [FW-1:0] polar_f_reg, polar_f_next, mag, sym_f;
  logic [PW-1:0]      polar_p_reg, polar_p_next;
  logic               cur_bit_reg, cur_bit_next, samp_pulse_reg, samp_pulse_next;
  logic               pop_one, pop_two, push, boundary, load, sym_sign, is_4;
  logic [1:0]         sym;
  logic [27:0]        dev_base, dev_word, dev_third;
  logic signed [FW+7:0] pprod;
  logic [PW-1:0]      pbyte;

  assign active = (state_reg == ST_RUN);
  assign is_4 = (mode_reg.mod_type == `MT_4FSK) || (mode_reg.mod_type == `MT_4GFSK);

  // register writes, commands and one-cycle read data
  always_comb
  begin
    mode_next = mode_reg;
    dev_next = dev_reg;
    rate_next = rate_reg;
    table_next = power_level_table_reg;
    rdata_next = '0;
    start_cmd = 1'b0;
    abort_command = 1'b0;
    tidx = bus_in.addr[`TIDX_MSB:`TIDX_LSB];
    if (bus_in.wr && bus_in.addr[`TABLE_SEL])
      table_next[tidx] = bus_in.wdata[PW-1:0];
    else if (bus_in.wr)
    begin
      case (bus_in.addr)
        `OFF_MODE: mode_next = mode_cfg_type'(bus_in.wdata[$bits(mode_cfg_type)-1:0]);
        `OFF_DEV:  dev_next = dev_cfg_type'(bus_in.wdata[$bits(dev_cfg_type)-1:0]);
        `OFF_RATE: rate_next = rate_cfg_type'(bus_in.wdata[$bits(rate_cfg_type)-1:0]);
        `OFF_CMD:
        begin
          start_cmd = bus_in.wdata[`CMD_START];
          abort_command = bus_in.wdata[`CMD_ABORT];
        end
        default: ;
      endcase
    end
    if (bus_in.rd && bus_in.addr[`TABLE_SEL])
      rdata_next = 32'(power_level_table_reg[tidx]);
    else if (bus_in.rd)
    begin
      case (bus_in.addr)
        `OFF_MODE: rdata_next = 32'(mode_reg);
        `OFF_DEV:  rdata_next = 32'(dev_reg);
        `OFF_RATE: rdata_next = 32'(rate_reg);
        `OFF_STAT: rdata_next = 32'({power_level_table_out, cnt_reg, active});
        default:   rdata_next = '0;  // unmapped and command reads give zero
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      mode_reg <= '0;
      dev_reg <= '0;
      rate_reg <= '0;
      power_level_table_reg <= '{default: '0};
      rdata_reg <= '0;
    end
    else if (ce_in)
    begin
      mode_reg <= mode_next;
      dev_reg <= dev_next;
      rate_reg <= rate_next;
      power_level_table_reg <= table_next;
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_out = rdata_reg;

  // outer deviation word, rounded as d*b/8 scaling demands
  always_comb
  begin
    if (dev_reg.fdev_e == '0)
      dev_base = 28'(dev_reg.fdev_m);
    else
      dev_base = (`DEV_BASE_ADD + 28'(dev_reg.fdev_m)) << (dev_reg.fdev_e - 4'h1);
    dev_word = ((dev_base << (`DB_SHIFT + {2'h0, dev_reg.ref_div_en}
                + {2'h0, dev_reg.band_sel_mid})) + `DEV_ROUND) >> `DEV_DIV_SHIFT;
    dev_third = dev_word / `INNER_DIV;
  end

  a_dev_plain: assert property (
    (dev_reg.fdev_e == '0 && !dev_reg.ref_div_en && dev_reg.band_sel_mid)
      |-> dev_word == 28'(dev_reg.fdev_m))
    else $error("plain mantissa deviation wrong");
  a_inner_third: assert property (
    (28'(dev_third * `INNER_DIV) <= dev_word)
      && (dev_word - 28'(dev_third * `INNER_DIV) < `INNER_DIV))
    else $error("inner deviation is not a third");

  // symbol extraction and constellation mapping
  always_comb
  begin
    src = (bits_reg == '0) ? buf_reg[0] : shift_reg;
    bps = is_4 ? 4'h2 : 4'h1;
    if (!is_4)
      sym = {1'b0, src[`BYTE_MSB]};
    else if (mode_reg.symbol_bit_pair_swap)
      sym = {src[`BYTE_MSB-1], src[`BYTE_MSB]};
    else
      sym = src[`BYTE_MSB -: 2];
    sym_sign = (is_4 ? sym[1] : sym[0]) ^ mode_reg.const_map[1];
    mag = (!is_4 || (sym[0] ^ mode_reg.const_map[0])) ? FW'(dev_word) : FW'(dev_third);
    sym_f = sym_sign ? mag : -mag;
  end

  assign boundary = tick8_in && (phase_reg == `PHASE_LAST);
  assign load = active && boundary && (bits_reg != '0 || cnt_reg != '0)
                && (mode_reg.mod_type <= `MT_4GFSK || mode_reg.mod_type == `MT_ASK);
  assign push = byte_valid_in && byte_ready_out;
  assign byte_ready_out = active && (cnt_reg != `PAIR_LEN);
  assign pbyte = buf_reg[1];
  assign pprod = $signed({{(FW-28){1'b0}}, dev_word}) * $signed(buf_reg[0]);

  // transmit sequencing, byte pair buffer, symbol and polar registers
  always_comb
  begin
    state_next = state_reg;
    phase_next = tick8_in ? phase_reg + 3'h1 : phase_reg;
    cnt_next = cnt_reg;
    buf_next = buf_reg;
    shift_next = shift_reg;
    bits_next = bits_reg;
    prev_f_next = prev_f_reg;
    cur_f_next = cur_f_reg;
    cur_bit_next = cur_bit_reg;
    polar_f_next = polar_f_reg;
    polar_p_next = polar_p_reg;
    pop_one = load && (bits_reg == '0);
    pop_two = active && tick8_in && (mode_reg.mod_type == `MT_POLAR)
              && (cnt_reg == `PAIR_LEN);
    if (load)
    begin
      shift_next = src << bps;
      bits_next = ((bits_reg == '0) ? `BYTE_BITS : bits_reg) - bps;
      prev_f_next = cur_f_reg;
      cur_f_next = sym_f;
      cur_bit_next = src[`BYTE_MSB] ^ (mode_reg.const_map != '0);
    end
    if (pop_two)
    begin
      polar_f_next = FW'(pprod >>> `POLAR_SHIFT);
      polar_p_next = buf_reg[1];
      cnt_next = '0;
    end
    else if (pop_one)
    begin
      buf_next[0] = buf_reg[1];
      cnt_next = cnt_reg - 2'h1;
    end
    if (push)
    begin
      buf_next[cnt_next[0]] = byte_in;
      cnt_next = cnt_next + 2'h1;
    end
    // only the abort command ends a running transmission
    if (start_cmd)
      state_next = ST_RUN;
    if (abort_command)
      state_next = ST_IDLE;
    if (state_next == ST_IDLE)
    begin
      cnt_next = '0;
      bits_next = '0;
      phase_next = '0;
      prev_f_next = '0;
      cur_f_next = '0;
    end
    samp_pulse_next = (state_next == ST_RUN) && (tick8_in || !active);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      cnt_reg <= '0;
      buf_reg <= '{default: '0};
      shift_reg <= '0;
      bits_reg <= '0;
      prev_f_reg <= '0;
      cur_f_reg <= '0;
      cur_bit_reg <= 1'b0;
      polar_f_reg <= '0;
      polar_p_reg <= '0;
      samp_pulse_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      buf_reg <= buf_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      prev_f_reg <= prev_f_next;
      cur_f_reg <= cur_f_next;
      cur_bit_reg <= cur_bit_next;
      polar_f_reg <= polar_f_next;
      polar_p_reg <= polar_p_next;
      samp_pulse_reg <= samp_pulse_next;
    end
  end

  a_fsk2_sign: assert property (
    (ce_in && load && !is_4 && dev_word != '0 && !abort_command)
      |=> (cur_f_reg > 0) == $past(sym_sign))
    else $error("two-level sign mapping wrong");
  a_fsk4_outer: assert property (
    (ce_in && load && is_4 && mode_reg.const_map == '0 && !mode_reg.symbol_bit_pair_swap
      && src[`BYTE_MSB -: 2] == 2'h1 && !abort_command)
      |=> cur_f_reg == -$signed(FW'($past(dev_word))))
    else $error("symbol 01 is not minus outer deviation");
  a_polar_pair: assert property (
    (ce_in && pop_two) |=> polar_p_reg == $past(pbyte) && cnt_reg <= 2'h1)
    else $error("polar pair not consumed");
  a_run_holds: assert property (
    (ce_in && active && !abort_command) |=> active)
    else $error("transmission stopped without abort");
  a_abort_ends: assert property (
    (ce_in && abort_command) |=> !active && !byte_ready_out)
    else $error("abort did not stop transmission");

  // amplitude keying: table ramp and smoothing fir state
  logic [2:0]    ramp_idx_reg, ramp_idx_next, step_reg, step_next, max_idx;
  logic [7:0]    os_reg, os_next;
  logic [3:0]    fr_reg, fr_next, ones, frac;
  logic [PW-1:0] t0, tmax, ask_pwr;
  logic signed [PW+4:0] fir_step;
  logic          ask_tick;

  assign max_idx = mode_reg.max_power_entry_index;
  assign t0 = power_level_table_reg[0];
  assign tmax = power_level_table_reg[max_idx];
  assign ask_tick = active && tick8_in && (mode_reg.mod_type == `MT_ASK);

  always_comb
  begin
    ramp_idx_next = ramp_idx_reg;
    step_next = step_reg;
    os_next = os_reg;
    fr_next = fr_reg;
    ones = '0;
    if (ask_tick)
    begin
      os_next = {os_reg[`OS_N-2:0], cur_bit_reg};  // eight-fold oversampled bits
      if (cur_bit_reg && fr_reg < `OS_FULL)
        fr_next = fr_reg + 4'h1;
      else if (!cur_bit_reg && fr_reg != '0)
        fr_next = fr_reg - 4'h1;
      // each step lasts duration+1 eighths of a symbol
      if (step_reg >= mode_reg.ramp_step_duration)
      begin
        step_next = '0;
        if (cur_bit_reg && ramp_idx_reg < max_idx)
          ramp_idx_next = ramp_idx_reg + 3'h1;
        else if (!cur_bit_reg && ramp_idx_reg != '0)
          ramp_idx_next = ramp_idx_reg - 3'h1;
      end
      else
        step_next = step_reg + 3'h1;
    end
    for (int i = 0; i < `OS_N; i++)
      ones = ones + 4'(os_reg[i]);
    if (mode_reg.fir_config == `FIR_FILTER)
      frac = ones;
    else if (mode_reg.fir_config == `FIR_RAMP)
      frac = fr_reg;
    else
      frac = cur_bit_reg ? `OS_FULL : 4'h0;
    fir_step = ($signed({1'b0, tmax}) - $signed({1'b0, t0})) * $signed({1'b0, frac});
    if (mode_reg.smoothing_fir_enable)
      ask_pwr = t0 + PW'(fir_step >>> `OS_SHIFT);
    else if (t0 != '0)
      ask_pwr = power_level_table_reg[ramp_idx_reg];
    else
      ask_pwr = cur_bit_reg ? tmax : t0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ramp_idx_reg <= '0;
      step_reg <= '0;
      os_reg <= '0;
      fr_reg <= '0;
    end
    else if (ce_in)
    begin
      ramp_idx_reg <= ramp_idx_next;
      step_reg <= step_next;
      os_reg <= os_next;
      fr_reg <= fr_next;
    end
  end

  a_ramp_up: assert property (
    (ce_in && ask_tick && cur_bit_reg && step_reg >= mode_reg.ramp_step_duration
      && ramp_idx_reg < max_idx) |=> ramp_idx_reg == $past(ramp_idx_reg) + 3'h1)
    else $error("power ramp did not step up");

  // samples per channel: 0 frequency, 1 power
  logic signed [FW-1:0] samp [2];
  logic signed [FW-1:0] shaped;
  logic signed [FW+8:0] gprod;
  logic [63:0]          gtab;
  logic [7:0]           gcoef;

  always_comb
  begin
    gtab = mode_reg.gaussian_bandwidth_select ? `GAUSS_BT05 : `GAUSS_BT1;
    gcoef = gtab[{phase_reg, 3'h0} +: `GC_W];
    gprod = (cur_f_reg - prev_f_reg) * $signed({1'b0, gcoef});
    shaped = prev_f_reg + FW'(gprod >>> `GAUSS_SHIFT);
    samp[0] = '0;
    samp[1] = FW'(tmax);
    case (mode_reg.mod_type)
      `MT_2FSK, `MT_4FSK:   samp[0] = cur_f_reg;
      `MT_2GFSK, `MT_4GFSK: samp[0] = shaped;
      `MT_ASK:              samp[1] = FW'(ask_pwr);
      `MT_POLAR:
      begin
        samp[0] = polar_f_reg;
        samp[1] = FW'(polar_p_reg);
      end
      default: ;  // carrier and unused codes: no deviation, max power
    endcase
  end

  // interpolation tick and factor from the data-rate setting
  logic [3:0] tick_cnt_reg, tick_cnt_next, tick_space;
  logic [2:0] log2n;
  logic       itick;

  always_comb
  begin
    if (rate_reg.rate_e >= `RATE_E_SCALE)
      tick_space = `TICK_SLOW
        - 4'(({1'b0, rate_reg.rate_m} + 17'h1) >> `TICK_M_SHIFT);
    else
      tick_space = `TICK_SLOW;
    if (rate_reg.rate_e >= `RATE_E_OFF)
      log2n = '0;
    else if (rate_reg.rate_e >= `RATE_E_SCALE)
      log2n = 3'(`RATE_E_OFF - rate_reg.rate_e);
    else
      log2n = `LOG2_MAX;
    itick = active && (tick_cnt_reg >= tick_space - 4'h1);
    tick_cnt_next = itick || !active ? 4'h0 : tick_cnt_reg + 4'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      tick_cnt_reg <= '0;
    else if (ce_in)
      tick_cnt_reg <= tick_cnt_next;
  end

  a_tick_range: assert property (
    (rate_reg.rate_e >= `RATE_E_SCALE)
      |-> (tick_space >= `TICK_FAST && tick_space <= `TICK_SLOW))
    else $error("tick spacing out of range");
  a_interp_off: assert property (
    (rate_reg.rate_e == `RATE_E_OFF) |-> log2n == '0)
    else $error("interpolation not disabled");

  // linear interpolation engine, one per channel
  logic signed [FW-1:0] cur_out [2];
  for (genvar c = 0; c < 2; c++)
  begin : g_interp
    logic signed [FW-1:0] base_reg, base_next, targ_reg, targ_next;
    logic [6:0]           k_reg, k_next;
    logic signed [FW+8:0] iprod;
    logic                 en;

    assign en = (c == 0) ? mode_reg.shaping_interp_enable : mode_reg.power_interp_enable;
    always_comb
    begin
      base_next = base_reg;
      targ_next = targ_reg;
      k_next = k_reg;
      if (samp_pulse_reg)
      begin
        base_next = cur_out[c];
        targ_next = samp[c];
        k_next = '0;
      end
      else if (!active)
      begin
        // idle drops the old target so a new run never replays the last one
        base_next = '0;
        targ_next = '0;
        k_next = '0;
      end
      else if (itick && k_reg < (7'h1 << log2n))
        k_next = k_reg + 7'h1;
      iprod = (targ_reg - base_reg) * $signed({2'h0, k_reg});
    end
    // step count limited by tick rate; slow symbols simply reach the target early
    assign cur_out[c] = en ? base_reg + FW'(iprod >>> log2n) : targ_reg;

    always_ff @(posedge mclk_in)
    begin
      if (srst_in)
      begin
        base_reg <= '0;
        targ_reg <= '0;
        k_reg <= '0;
      end
      else if (ce_in)
      begin
        base_reg <= base_next;
        targ_reg <= targ_next;
        k_reg <= k_next;
      end
    end
  end

  // registered outputs to synthesizer and amplifier
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      freq_word_out <= '0;
      power_level_table_out <= '0;
    end
    else if (ce_in)
    begin
      freq_word_out <= active ? cur_out[0] : '0;
      power_level_table_out <= active ? cur_out[1][PW-1:0] : '0;
    end
  end
  assign tx_active_out = active;

  a_ook_level: assert property (
    (ce_in && samp_pulse_reg && active && mode_reg.mod_type == `MT_ASK && t0 == '0
      && !mode_reg.smoothing_fir_enable && !mode_reg.power_interp_enable
      && !bus_in.wr) ##1 (ce_in && !bus_in.wr && active)
      |=> power_level_table_out == $past(ask_pwr, 2))
    else $error("on-off level not applied");

endmodule : digital_fsk_ask_modulator
`default_nettype wire

// ===== test/synth_pa_model.sv
`timescale 1ns/1ps
`default_nettype none
module synth_pa_model #(
  parameter int FW     = 30,     // deviation word width
  parameter int CENTRE = 32'h3E8 // centre word, arbitrary
) (
  input  wire logic                 clk_in,   // modulator clock
  input  wire logic signed [FW-1:0] dev_in,   // deviation word
  input  wire logic [7:0]           power_in, // power code
  output logic signed [FW:0]        freq_out, // carrier word
  output logic [7:0]                level_out // applied power
);
  // carrier sits at centre plus deviation; power code applied as given
  always @(posedge clk_in)
  begin
    freq_out  <= (FW+1)'(CENTRE + dev_in);
    level_out <= power_in;
  end
endmodule : synth_pa_model
`default_nettype wire

// ===== test/digital_fsk_ask_modulator_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module digital_fsk_ask_modulator_test;
  import modulator_pkg::*;
  logic               mclk_in = 1'b0;
  logic               srst_in = 1'b1;
  bus_req_type        bus = '0;
  logic               tick = 1'b0;
  logic [3:0]         tcnt = 4'h0;
  logic [7:0]         byte_in = 8'h00;
  logic               valid = 1'b0;
  logic               idx = 1'b0;
  logic [7:0]         pat [2] = '{8'h00, 8'h00};
  logic [31:0]        rdata;
  logic               ready;
  logic               active;
  logic signed [29:0] fword;
  logic [7:0]         pword;
  logic signed [30:0] carrier;
  logic [7:0]         level;
  mode_cfg_type       cfg = '0;
  int                 n_mismatch = 0;
  int                 tests_run = 0;

  always #4 mclk_in = ~mclk_in;
  // eighth-symbol strobe every 16 clocks keeps symbols short
  always @(posedge mclk_in)
  begin
    tcnt <= tcnt + 4'h1;
    tick <= (tcnt == 4'hE);
  end
  // fifo stand-in: hands out pattern bytes in turn, so pairs stay aligned
  always @(posedge mclk_in)
  begin
    if (valid && ready)
    begin
      idx     <= ~idx;
      byte_in <= pat[~idx];
    end
  end

  digital_fsk_ask_modulator DUT (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1),
    .bus_in(bus), .rdata_out(rdata), .tick8_in(tick), .byte_in(byte_in),
    .byte_valid_in(valid), .byte_ready_out(ready), .freq_word_out(fword),
    .power_level_table_out(pword), .tx_active_out(active));
  synth_pa_model PA (.clk_in(mclk_in), .dev_in(fword), .power_in(pword),
    .freq_out(carrier), .level_out(level));

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd

  // waits, bounded, for the far side to see a value; sel picks power
  task automatic wait_v(input logic sel, input logic signed [30:0] e);
    int i;
    logic signed [30:0] v;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge mclk_in);
      #1 v = sel ? 31'(level) : carrier;
      if (v === e)
        break;
    end
    `CHK(v, e)
    if (i == 4000)
      wrap_up();
  endtask : wait_v

  task automatic run(input mode_cfg_type m, input logic [7:0] a, input logic [7:0] b);
    wr(6'h00, 32'(m));
    @(posedge mclk_in);
    pat[0] <= a;
    pat[1] <= b;
    idx <= 1'b0;
    byte_in <= a;
    valid <= 1'b1;
    wr(6'h0C, 32'h1);
  endtask : run

  task automatic halt;
    @(posedge mclk_in);
    valid <= 1'b0;
    wr(6'h0C, 32'h2);
    repeat (4) @(posedge mclk_in);
    #1 `CHK(active, 1'b0)
  endtask : halt

  task automatic t_regs;
    rd(6'h00, 32'h0);
    cfg.max_power_entry_index = 3'h3;
    cfg.const_map = 2'h1;
    cfg.output_filter_cutoff_code = 2'h3;
    wr(6'h00, 32'(cfg));
    rd(6'h00, 32'(cfg));
    wr(6'h04, 32'h000000C0);
    rd(6'h04, 32'h000000C0);
    wr(6'h2C, 32'h000000A5);
    rd(6'h2C, 32'h000000A5);
    rd(6'h14, 32'h0);
    $display("regs done");
  endtask : t_regs

  // deviation 0xC0, band divider 4, no reference divider: word 0x60
  task automatic t_fsk2;
    for (int c = 0; c < 4; c++)
    begin
      cfg.mod_type = c[1] ? 4'h2 : 4'h0;
      cfg.gaussian_bandwidth_select = c[0];
      cfg.const_map = 2'(c[0] * 2);
      run(cfg, 8'hFF, 8'hFF);
      wait_v(1'b0, c[0] ? 31'h388 : 31'h448);
      halt();
    end
    $display("fsk2 done");
  endtask : t_fsk2

  // byte 0x55 gives symbol 01, or 10 once pair bits are swapped
  task automatic t_fsk4;
    int k;
    for (int c = 0; c < 8; c++)
    begin
      cfg.mod_type = 4'h1;
      cfg.const_map = c[1:0];
      cfg.symbol_bit_pair_swap = c[2];
      run(cfg, 8'h55, 8'h55);
      k = (!c[2] ^ c[0]) ? 3 : 1;
      if (!(c[2] ^ c[1]))
        k = -k;
      wait_v(1'b0, 31'(32'h3E8 + 32 * k));
      halt();
    end
    $display("fsk4 done");
  endtask : t_fsk4

  task automatic t_ask;
    cfg.mod_type = 4'h5;
    cfg.symbol_bit_pair_swap = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      cfg.const_map = {1'b0, c[1]};
      cfg.smoothing_fir_enable = c[2];
      cfg.dig_smooth_enable = c[2];
      cfg.fir_config = {~(c[0] ^ c[1]), c[1]};
      run(cfg, c[0] ? 8'hFF : 8'h00, c[0] ? 8'hFF : 8'h00);
      // let symbols land first, so a zero level is not just the idle one
      repeat (400) @(posedge mclk_in);
      wait_v(1'b1, (c[0] ^ c[1]) ? 31'h0A5 : 31'h0);
      halt();
    end
    $display("ask done");
  endtask : t_ask

  // table ramping: entry zero nonzero, fir kept off
  task automatic t_ramp;
    wr(6'h20, 32'h00000011);
    cfg.smoothing_fir_enable = 1'b0;
    cfg.dig_smooth_enable = 1'b0;
    cfg.const_map = 2'h0;
    for (int c = 0; c < 2; c++)
    begin
      run(cfg, c[0] ? 8'hFF : 8'h00, c[0] ? 8'hFF : 8'h00);
      wait_v(1'b1, c[0] ? 31'h0A5 : 31'h011);
      halt();
    end
    wr(6'h20, 32'h00000000);
    $display("ramp done");
  endtask : t_ramp

  task automatic t_polar;
    cfg.mod_type = 4'h6;
    cfg.const_map = 2'h0;
    run(cfg, 8'h40, 8'h33);
    wait_v(1'b0, 31'h418);
    wait_v(1'b1, 31'h033);
    @(posedge mclk_in);
    pat[0] <= 8'hC0;
    pat[1] <= 8'h5A;
    wait_v(1'b0, 31'h3B8);
    wait_v(1'b1, 31'h05A);
    halt();
    $display("polar done");
  endtask : t_polar

  // carrier must still be up long after start; plain-mantissa deviation set
  task automatic t_cw;
    cfg.mod_type = 4'h7;
    wr(6'h04, 32'h000020C0);
    run(cfg, 8'h00, 8'h00);
    repeat (3000) @(posedge mclk_in);
    #1 `CHK(active, 1'b1)
    wait_v(1'b0, 31'h3E8);
    rd(6'h10, 32'h0000052D);
    halt();
    $display("cw done");
  endtask : t_cw

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_regs();
    t_fsk2();
    t_fsk4();
    t_ask();
    t_ramp();
    t_polar();
    t_cw();
    wrap_up();
  end
endmodule : digital_fsk_ask_modulator_test
`default_nettype wire
